// ===== pls_consts.svh
// Constants for the synthesizer control register logic
// Functional notes
// - Doubler bit selects doubled or direct reference
// - Falling edge only, or both edges doubled
// - Halver bit adds divide-by-two toggle stage
// - Ten-bit reference divide ratio, 1 to 1023
// - Double-buffer bit shadows output divider select
// - Shadowed bits applied on select-000 write
// - Lock count 40 cycles, or 5 cycles
// - Lock window 10 ns, or 6 ns
// - Lock after consecutive cycles inside window
// - Sleep bit powers down, registers kept
// - Sleep: counters load, pump off, unlock, mute
// - Tristate bit floats charge pump output
// - Counter-reset bit holds both dividers reset
// - Select codes 011, 100, 101 route words
// - Select code 010 loads reference register
// - Boost cell on until tuning nears lock
// - Divider mode 00 off, 10 resync timeout
// - Feedback from oscillator or output dividers
// - Mute-until-lock holds output off until locked
// - Output enable bit and two-bit power level
// - Charge cancellation bit enables cancellation
`ifndef PLS_CONSTS_SVH
`define PLS_CONSTS_SVH

`define PLS_WORD_W 32
`define PLS_SEL_MSB 2
`define PLS_SEL_R0 3'h0
`define PLS_SEL_R2 3'h2
`define PLS_SEL_R3 3'h3
`define PLS_SEL_R4 3'h4
`define PLS_SEL_R5 3'h5

// Reference, lock and power register fields
`define PLS_R2_DOUBLER 25
`define PLS_R2_HALVER 24
`define PLS_R2_RDIV_MSB 23
`define PLS_R2_RDIV_LSB 14
`define PLS_R2_DBLBUF 13
`define PLS_R2_CP_MSB 11
`define PLS_R2_CP_LSB 9
`define PLS_R2_LCOUNT 8
`define PLS_R2_LWIN 7
`define PLS_R2_SLEEP 5
`define PLS_R2_CPTRI 4
`define PLS_R2_CTRRST 3

// Boost and clock divider register fields
`define PLS_R3_BOOST 18
`define PLS_R3_MODE_MSB 16
`define PLS_R3_MODE_LSB 15
`define PLS_R3_DIV_MSB 14
`define PLS_R3_DIV_LSB 3
`define PLS_MODE_OFF 2'h0
`define PLS_MODE_RESYNC 2'h2

// Output register fields
`define PLS_R4_FBSEL 23
`define PLS_R4_DSEL_MSB 22
`define PLS_R4_DSEL_LSB 20
`define PLS_R4_MUTE 10
`define PLS_R4_OUTEN 5
`define PLS_R4_PWR_MSB 4
`define PLS_R4_PWR_LSB 3

// Lock pin and phase detector register fields
`define PLS_R5_ABP_MSB 31
`define PLS_R5_ABP_LSB 30
`define PLS_R5_CCAN 29
`define PLS_R5_LDPIN_MSB 23
`define PLS_R5_LDPIN_LSB 22

// Lock detector: counts in cycles, windows in tenths of a nanosecond
`define PLS_LOCK_LONG 6'h28
`define PLS_LOCK_SHORT 6'h05
`define PLS_WIN_WIDE 8'h64
`define PLS_WIN_NARROW 8'h3c

`define PLS_RDIV_ONE 10'h001
`define PLS_LOCK_STEP 6'h01
`define PLS_RESYNC_LAST 12'h001
`define PLS_WORD_RESET 32'h00000000

`endif

// ===== pls_pkg.sv
// Types shared by the synthesizer control register logic
package pls_pkg;

    typedef struct packed {
        logic [2:0] output_div_sel;
        logic [1:0] output_power;
        logic [2:0] cp_current;
        logic [1:0] antibacklash;
        logic [1:0] lock_pin_mode;
        logic output_enable;
        logic feedback_direct;
        logic charge_cancel;
        logic cp_tristate;
        logic counter_reset;
        logic boost_active;
    } pls_synth_ctl_type;

    typedef struct packed {
        logic serial_clock;
        logic serial_data;
        logic load_enable;
    } pls_serial_type;

endpackage

// ===== pls_ctrl_regs.sv
// Serial-loaded control registers, reference path and lock detector
`timescale 1ns/1ps
`include "pls_consts.svh"

module pls_ctrl_regs
    import pls_pkg::*;
#(
    parameter int RDIV_W = 10,
    parameter int TIMEOUT_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire pls_serial_type serial_pins,
    input wire logic reference_in,
    input wire logic phase_err_valid,
    input wire logic [7:0] phase_err,
    input wire logic tune_near_lock,
    output pls_synth_ctl_type synth_ctl,
    output logic phase_detector_ref,
    output logic lock_indicator_pin,
    output logic resync_pulse,
    output logic reg0_written
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    pls_serial_type ser_meta;
    pls_serial_type ser_sync;
    pls_serial_type ser_last;
    logic ref_meta;
    logic ref_sync;
    logic ref_last;

    always_ff @(posedge clk) begin
        if (rst) begin
            ser_meta <= '0;
            ser_sync <= '0;
            ser_last <= '0;
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_last <= 1'b0;
        end else begin
            ser_meta <= serial_pins;
            ser_sync <= ser_meta;
            ser_last <= ser_sync;
            ref_meta <= reference_in;
            ref_sync <= ref_meta;
            ref_last <= ref_sync;
        end
    end

    logic sclk_rise;
    logic load_rise;
    assign sclk_rise = ser_sync.serial_clock & ~ser_last.serial_clock;
    assign load_rise = ser_sync.load_enable & ~ser_last.load_enable;

    // ****************************************************************
    // Serial shift register and word routing
    // ****************************************************************
    logic [`PLS_WORD_W-1:0] shift_word;
    logic [`PLS_WORD_W-1:0] reference_and_lock_config;
    logic [`PLS_WORD_W-1:0] boost_and_resync_config;
    logic [`PLS_WORD_W-1:0] output_stage_config;
    logic [`PLS_WORD_W-1:0] lock_pin_and_detector_config;
    logic [2:0] register_select_bits;

    assign register_select_bits = shift_word[`PLS_SEL_MSB:0];

    // Words enter MSB first; the select code ends up in the low bits
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_word <= `PLS_WORD_RESET;
        end else if (sclk_rise) begin
            shift_word <= {shift_word[`PLS_WORD_W-2:0], ser_sync.serial_data};
        end
    end

    // Input registers keep loading even while asleep
    always_ff @(posedge clk) begin
        if (rst) begin
            reference_and_lock_config <= `PLS_WORD_RESET;
            boost_and_resync_config <= `PLS_WORD_RESET;
            output_stage_config <= `PLS_WORD_RESET;
            lock_pin_and_detector_config <= `PLS_WORD_RESET;
        end else if (load_rise) begin
            unique case (register_select_bits)
                `PLS_SEL_R2: reference_and_lock_config <= shift_word;
                `PLS_SEL_R3: boost_and_resync_config <= shift_word;
                `PLS_SEL_R4: output_stage_config <= shift_word;
                `PLS_SEL_R5: lock_pin_and_detector_config <= shift_word;
                default: begin
                end
            endcase
        end
    end

    logic reg0_load;
    assign reg0_load = load_rise && (register_select_bits == `PLS_SEL_R0);

    always_ff @(posedge clk) begin
        if (rst) begin
            reg0_written <= 1'b0;
        end else begin
            reg0_written <= reg0_load;
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    logic doubler_on;
    logic reference_halver;
    logic [RDIV_W-1:0] rdiv_ratio;
    logic double_buffer_on;
    logic lock_cycle_count_select;
    logic lock_window_select;
    logic sleep_request;
    logic counter_hold;
    logic output_mute_until_lock;
    logic [1:0] clkdiv_mode;
    logic [TIMEOUT_W-1:0] clkdiv_value;

    assign doubler_on = reference_and_lock_config[`PLS_R2_DOUBLER];
    assign reference_halver = reference_and_lock_config[`PLS_R2_HALVER];
    assign rdiv_ratio = reference_and_lock_config[`PLS_R2_RDIV_MSB:`PLS_R2_RDIV_LSB];
    assign double_buffer_on = reference_and_lock_config[`PLS_R2_DBLBUF];
    assign lock_cycle_count_select = reference_and_lock_config[`PLS_R2_LCOUNT];
    assign lock_window_select = reference_and_lock_config[`PLS_R2_LWIN];
    assign sleep_request = reference_and_lock_config[`PLS_R2_SLEEP];
    // Sleep forces counters to load state like a counter reset
    assign counter_hold = reference_and_lock_config[`PLS_R2_CTRRST] | sleep_request;
    assign output_mute_until_lock = output_stage_config[`PLS_R4_MUTE];
    assign clkdiv_mode = boost_and_resync_config[`PLS_R3_MODE_MSB:`PLS_R3_MODE_LSB];
    assign clkdiv_value = boost_and_resync_config[`PLS_R3_DIV_MSB:`PLS_R3_DIV_LSB];

    // ****************************************************************
    // Shared decode and arithmetic
    // ****************************************************************
    // Divider select field of an output register word
    function automatic logic [2:0] div_sel_field(input logic [`PLS_WORD_W-1:0] word);
        return word[`PLS_R4_DSEL_MSB:`PLS_R4_DSEL_LSB];
    endfunction

    // One more in-window cycle; saturation is left to the caller
    function automatic logic [5:0] lock_step(input logic [5:0] count);
        return count + `PLS_LOCK_STEP;
    endfunction

    // ****************************************************************
    // Output divider select double buffer
    // ****************************************************************
    logic [2:0] active_div_sel;

    always_ff @(posedge clk) begin
        if (rst) begin
            active_div_sel <= '0;
        end else if (!double_buffer_on) begin
            active_div_sel <= div_sel_field(output_stage_config);
        end else if (reg0_load) begin
            // Shadowed bits wait here; the input register itself still loads
            active_div_sel <= div_sel_field(output_stage_config);
        end
    end

    // ****************************************************************
    // Reference path: doubler, divider, halver
    // ****************************************************************
    logic ref_edge;
    logic [RDIV_W-1:0] rdiv_count;
    logic rdiv_tick;
    logic halver_state;
    logic pfd_event;

    // Doubling the frequency is done by counting both edges
    assign ref_edge = doubler_on ? (ref_sync ^ ref_last)
                                 : (ref_last & ~ref_sync);

    // Ratio 0 is not allowed and is treated as 1
    assign rdiv_tick = ref_edge &&
        ((rdiv_count >= rdiv_ratio) || (rdiv_ratio <= `PLS_RDIV_ONE));

    always_ff @(posedge clk) begin
        if (rst || counter_hold) begin
            rdiv_count <= `PLS_RDIV_ONE;
        end else if (rdiv_tick) begin
            rdiv_count <= `PLS_RDIV_ONE;
        end else if (ref_edge) begin
            rdiv_count <= rdiv_count + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || counter_hold) begin
            halver_state <= 1'b0;
        end else if (rdiv_tick) begin
            halver_state <= ~halver_state;
        end
    end

    // With the halver, one phase detector cycle per two divider ticks
    assign pfd_event = rdiv_tick && (!reference_halver || halver_state);

    always_ff @(posedge clk) begin
        if (rst || counter_hold) begin
            phase_detector_ref <= 1'b0;
        end else if (reference_halver) begin
            if (rdiv_tick) begin
                phase_detector_ref <= ~halver_state;
            end
        end else begin
            phase_detector_ref <= rdiv_tick;
        end
    end

    // ****************************************************************
    // Digital lock detector
    // ****************************************************************
    logic [5:0] lock_count;
    logic [5:0] lock_target;
    logic [7:0] lock_window;
    logic in_window;

    assign lock_target = lock_cycle_count_select ? `PLS_LOCK_SHORT
                                                 : `PLS_LOCK_LONG;
    assign lock_window = lock_window_select ? `PLS_WIN_NARROW
                                            : `PLS_WIN_WIDE;
    // An error equal to the window counts as outside it
    assign in_window = phase_err < lock_window;

    always_ff @(posedge clk) begin
        if (rst || sleep_request) begin
            lock_count <= '0;
            lock_indicator_pin <= 1'b0;
        end else if (phase_err_valid) begin
            if (!in_window) begin
                lock_count <= '0;
                lock_indicator_pin <= 1'b0;
            end else if (lock_step(lock_count) >= lock_target) begin
                lock_count <= lock_target;
                lock_indicator_pin <= 1'b1;
            end else begin
                lock_count <= lock_step(lock_count);
            end
        end
    end

    // ****************************************************************
    // Phase resync timeout
    // ****************************************************************
    logic [TIMEOUT_W-1:0] resync_count;
    logic resync_armed;

    // Armed by each frequency update; counts phase detector cycles
    always_ff @(posedge clk) begin
        if (rst || counter_hold || clkdiv_mode != `PLS_MODE_RESYNC) begin
            resync_count <= '0;
            resync_armed <= 1'b0;
            resync_pulse <= 1'b0;
        end else if (reg0_load) begin
            resync_count <= clkdiv_value;
            resync_armed <= 1'b1;
            resync_pulse <= 1'b0;
        end else if (resync_armed && pfd_event) begin
            // A zero timeout fires on the very first phase detector cycle
            resync_count <= resync_count - 1'b1;
            resync_armed <= (resync_count > `PLS_RESYNC_LAST);
            resync_pulse <= (resync_count <= `PLS_RESYNC_LAST);
        end else begin
            resync_pulse <= 1'b0;
        end
    end

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            synth_ctl <= '0;
        end else begin
            synth_ctl.output_div_sel <= active_div_sel;
            synth_ctl.output_power <=
                output_stage_config[`PLS_R4_PWR_MSB:`PLS_R4_PWR_LSB];
            synth_ctl.cp_current <=
                reference_and_lock_config[`PLS_R2_CP_MSB:`PLS_R2_CP_LSB];
            synth_ctl.antibacklash <=
                lock_pin_and_detector_config[`PLS_R5_ABP_MSB:`PLS_R5_ABP_LSB];
            synth_ctl.lock_pin_mode <=
                lock_pin_and_detector_config[`PLS_R5_LDPIN_MSB:`PLS_R5_LDPIN_LSB];
            // Output stays off while asleep or muted awaiting lock
            synth_ctl.output_enable <= output_stage_config[`PLS_R4_OUTEN] &&
                !sleep_request &&
                !(output_mute_until_lock && !lock_indicator_pin);
            synth_ctl.feedback_direct <= output_stage_config[`PLS_R4_FBSEL];
            synth_ctl.charge_cancel <= lock_pin_and_detector_config[`PLS_R5_CCAN];
            synth_ctl.cp_tristate <=
                reference_and_lock_config[`PLS_R2_CPTRI] | sleep_request;
            synth_ctl.counter_reset <= counter_hold;
            synth_ctl.boost_active <= boost_and_resync_config[`PLS_R3_BOOST] &&
                !tune_near_lock && !sleep_request;
        end
    end

endmodule

// ===== pls_host_model.sv
// Host model driving the three-wire serial load pins
`timescale 1ns/1ps
module pls_host_model
    import pls_pkg::*;
(
    input wire logic clk,
    output pls_serial_type pins
);
    initial pins = '0;
    // Four cycles per level: one more than the pin synchronisers need
    task automatic hold4;
        repeat (4) @(posedge clk);
    endtask
    task automatic send(input logic [31:0] word);
        @(posedge clk);
        for (int i = 31; i >= 0; i--) begin
            pins.serial_data <= word[i];
            hold4();
            pins.serial_clock <= 1'b1;
            hold4();
            pins.serial_clock <= 1'b0;
        end
        // Data is stale once shifted, so show its inverse
        pins.serial_data <= ~word[0];
        pins.load_enable <= 1'b1;
        hold4();
        pins.load_enable <= 1'b0;
        hold4();
    endtask
endmodule

// ===== pls_ctrl_regs_props.sv
// Port-level assertions for the control register logic
`timescale 1ns/1ps
module pls_ctrl_regs_props
    import pls_pkg::*;
#(
    parameter int RDIV_W = 10,
    parameter int TIMEOUT_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire pls_serial_type serial_pins,
    input wire logic reference_in,
    input wire logic phase_err_valid,
    input wire logic [7:0] phase_err,
    input wire logic tune_near_lock,
    input wire pls_synth_ctl_type synth_ctl,
    input wire logic phase_detector_ref,
    input wire logic lock_indicator_pin,
    input wire logic resync_pulse,
    input wire logic reg0_written
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_bad_sample;
        phase_err_valid && phase_err >= 8'h64;
    endsequence
    sequence s_load_recent;
        $past(serial_pins.load_enable, 3) || $past(serial_pins.load_enable, 5);
    endsequence
    property p_lock_rise;
        $rose(lock_indicator_pin) |-> $past(phase_err_valid) && $past(phase_err) < 8'h64;
    endproperty
    property p_unlock;
        s_bad_sample |=> !lock_indicator_pin;
    endproperty
    property p_boost_off;
        tune_near_lock |=> !synth_ctl.boost_active;
    endproperty
    property p_r0_pulse;
        reg0_written |=> !reg0_written;
    endproperty
    property p_ctr_ref;
        synth_ctl.counter_reset [*3] |-> !phase_detector_ref;
    endproperty
    property p_ctr_resync;
        synth_ctl.counter_reset [*3] |-> !resync_pulse;
    endproperty
    property p_reset_clear;
        $fell(rst) |-> synth_ctl == '0 && !lock_indicator_pin;
    endproperty
    property p_load_only;
        $changed(synth_ctl.charge_cancel) |-> s_load_recent;
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rose without good sample");
    a_unlock: assert property (p_unlock) else $error("lock kept after bad sample");
    a_boost_off: assert property (p_boost_off) else $error("boost kept near lock");
    a_r0_pulse: assert property (p_r0_pulse) else $error("select zero pulse too long");
    a_ctr_ref: assert property (p_ctr_ref) else $error("reference ran in reset");
    a_ctr_resync: assert property (p_ctr_resync) else $error("resync ran in reset");
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
    a_load_only: assert property (p_load_only) else $error("field moved without load");
endmodule

bind pls_ctrl_regs pls_ctrl_regs_props #(.RDIV_W(RDIV_W), .TIMEOUT_W(TIMEOUT_W))
    pls_ctrl_regs_props_i (.clk(clk), .rst(rst), .serial_pins(serial_pins),
    .reference_in(reference_in), .phase_err_valid(phase_err_valid),
    .phase_err(phase_err), .tune_near_lock(tune_near_lock), .synth_ctl(synth_ctl),
    .phase_detector_ref(phase_detector_ref), .lock_indicator_pin(lock_indicator_pin),
    .resync_pulse(resync_pulse), .reg0_written(reg0_written));

// ===== pls_ctrl_regs_bench.sv
// Self-checking bench for the control register logic
`timescale 1ns/1ps
module pls_ctrl_regs_bench;
    import pls_pkg::*;
    logic clk;
    logic rst;
    pls_serial_type serial_pins;
    logic reference_in;
    logic phase_err_valid;
    logic [7:0] phase_err;
    logic tune_near_lock;
    pls_synth_ctl_type synth_ctl;
    logic phase_detector_ref;
    logic lock_indicator_pin;
    logic resync_pulse;
    logic reg0_written;
    int n_errors = 0;
    int compares = 0;
    int ticks = 0;
    int resyncs = 0;
    int r0_pulses = 0;
    logic ref_prev;
    // Last word halves after the divider: eight ticks make four rises
    logic [31:0] ref_words [4] = '{32'h00008002, 32'h02008002, 32'h0000800a, 32'h01004002};
    int ref_exp [4] = '{4, 8, 0, 4};
    int rsy_exp [4] = '{1, 0, 0, 0};
    pls_host_model pls_host_model_i (.clk(clk), .pins(serial_pins));
    pls_ctrl_regs pls_ctrl_regs_i (.clk(clk), .rst(rst), .serial_pins(serial_pins),
        .reference_in(reference_in), .phase_err_valid(phase_err_valid),
        .phase_err(phase_err), .tune_near_lock(tune_near_lock), .synth_ctl(synth_ctl),
        .phase_detector_ref(phase_detector_ref), .lock_indicator_pin(lock_indicator_pin),
        .resync_pulse(resync_pulse), .reg0_written(reg0_written));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Rises are counted, so pulses and halved levels both count once per period
    always @(posedge clk) begin
        ref_prev <= phase_detector_ref;
        if (phase_detector_ref === 1'b1 && ref_prev !== 1'b1) ticks <= ticks + 1;
        if (resync_pulse === 1'b1) resyncs <= resyncs + 1;
        if (reg0_written === 1'b1) r0_pulses <= r0_pulses + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Checks follow 1 ns after the edge so registered outputs have landed
    task automatic wr(input logic [31:0] w);
        pls_host_model_i.send(w);
        #1;
    endtask
    task automatic sample(input logic [7:0] e, input int n);
        repeat (n) begin
            @(posedge clk);
            phase_err <= e;
            phase_err_valid <= 1'b1;
            @(posedge clk);
            phase_err_valid <= 1'b0;
        end
        @(posedge clk);
        #1;
    endtask
    initial begin
        // About four times the expected length of the run
        #400000;
        n_errors++;
        close_out();
    end
    // ***********************************************
    // Main sequence
    // ***********************************************
    initial begin
        int t0;
        int s0;
        rst = 1'b1;
        reference_in = 1'b0;
        phase_err_valid = 1'b0;
        phase_err = 8'h00;
        tune_near_lock = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wr(32'h20c00005);
        check("cancel", synth_ctl.charge_cancel, 1);
        check("abp", synth_ctl.antibacklash, 0);
        check("ld mode", synth_ctl.lock_pin_mode, 3);
        wr(32'h00d00434);
        check("div sel", synth_ctl.output_div_sel, 5);
        check("fb", synth_ctl.feedback_direct, 1);
        check("power", synth_ctl.output_power, 2);
        check("muted", synth_ctl.output_enable, 0);
        wr(32'h00050023);
        check("boost", synth_ctl.boost_active, 1);
        @(posedge clk);
        tune_near_lock <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("boost", synth_ctl.boost_active, 0);
        wr(32'h00000b82);
        check("cp", synth_ctl.cp_current, 5);
        sample(8'h3b, 4);
        check("lock", lock_indicator_pin, 0);
        sample(8'h3b, 1);
        check("lock", lock_indicator_pin, 1);
        sample(8'h00, 0);
        check("unmuted", synth_ctl.output_enable, 1);
        sample(8'h3c, 1);
        check("lock", lock_indicator_pin, 0);
        wr(32'h00000002);
        sample(8'h63, 39);
        check("lock", lock_indicator_pin, 0);
        sample(8'h63, 1);
        check("lock", lock_indicator_pin, 1);
        sample(8'h64, 1);
        check("lock", lock_indicator_pin, 0);
        sample(8'h63, 40);
        check("lock", lock_indicator_pin, 1);
        wr(32'h00000022);
        check("lock", lock_indicator_pin, 0);
        check("tristate", synth_ctl.cp_tristate, 1);
        check("ctr", synth_ctl.counter_reset, 1);
        check("out", synth_ctl.output_enable, 0);
        wr(32'h00000012);
        check("tristate", synth_ctl.cp_tristate, 1);
        check("ctr", synth_ctl.counter_reset, 0);
        check("div sel", synth_ctl.output_div_sel, 5);
        wr(32'h00002002);
        wr(32'h00b00434);
        check("div sel", synth_ctl.output_div_sel, 5);
        wr(32'h00000000);
        check("div sel", synth_ctl.output_div_sel, 3);
        check("r0 pulse", r0_pulses, 1);
        for (int j = 0; j < 4; j++) begin
            wr(ref_words[j]);
            t0 = ticks;
            s0 = resyncs;
            for (int k = 0; k < 16; k++) begin
                repeat (10) @(posedge clk);
                reference_in <= ~reference_in;
            end
            repeat (10) @(posedge clk);
            #1;
            check("ticks", ticks - t0, ref_exp[j]);
            check("resyncs", resyncs - s0, rsy_exp[j]);
        end
        close_out();
    end
endmodule
